/* File: rpo_pkg.sv */
package rpo_pkg;

    // ----------------------------------------------------------------
    // Widths and field positions
    // ----------------------------------------------------------------
    localparam int RPO_CHANNELS    = 4;
    localparam int RPO_RAW_WIDTH   = 10;
    localparam int RPO_DATA_WIDTH  = 8;
    localparam int RPO_STAT_WIDTH  = 3;
    localparam int RPO_RAW_HI_MSB  = 9;
    localparam int RPO_RAW_HI_LSB  = 2;
    localparam int RPO_RAW_LO_MSB  = 1;
    localparam int RPO_STAT_COMMA  = 2;

    // ----------------------------------------------------------------
    // Three-level decoder mode pin, coded on two wires
    // ----------------------------------------------------------------
    localparam logic [1:0] RPO_MODE_LOW  = 2'h0;
    localparam logic [1:0] RPO_MODE_MID  = 2'h1;
    localparam logic [1:0] RPO_MODE_HIGH = 2'h2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RPO_DATA_RESET = 8'h00;
    localparam logic [2:0] RPO_STAT_RESET = 3'h0;

    // One received character as it leaves the decoder stage.
    typedef struct packed {
        logic [9:0] raw;
        logic [7:0] decoded;
        logic [2:0] code;
        logic       comma;
    } rpo_char_type;

    // One presented output word.
    typedef struct packed {
        logic [7:0] data;
        logic [2:0] status;
    } rpo_out_type;

endpackage

/* File: rpo_channel.sv */
`timescale 1ns/1ps
module rpo_channel
    import rpo_pkg::*;
(
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    input  wire logic         recovered_clock_i,
    input  wire logic         training_level_i,
    input  wire logic         output_clock_select_i,
    input  wire logic [1:0]   decoder_mode_i,
    input  wire rpo_char_type char_i,
    output rpo_out_type       word_o,
    output logic              clock_out_o
);

    // ----------------------------------------------------------------
    // Clock pin sampling
    // ----------------------------------------------------------------
    logic        rec_meta;
    logic        rec_sync;
    logic        sel_prev;
    logic        sel_level;
    logic        sel_rise;
    rpo_out_type next_word;

    // Two-stage synchroniser for the recovered clock pin.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rec_meta <= 1'b0;
            rec_sync <= 1'b0;
        end else begin
            rec_meta <= recovered_clock_i;
            rec_sync <= rec_meta;
        end
    end

    // Select recovered or training clock and find its rising edge.
    assign sel_level = output_clock_select_i ? rec_sync : training_level_i;
    assign sel_rise  = sel_level & ~sel_prev;

    // Edge history and the forwarded interface clock.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sel_prev    <= 1'b0;
            clock_out_o <= 1'b0;
        end else begin
            sel_prev    <= sel_level;
            clock_out_o <= sel_level;
        end
    end

    // ----------------------------------------------------------------
    // Output register contents
    // ----------------------------------------------------------------
    // Form the presented word from the mode.
    always_comb begin
        if (decoder_mode_i == RPO_MODE_LOW) begin
            next_word.data                       = char_i.raw[RPO_RAW_HI_MSB:RPO_RAW_HI_LSB];
            next_word.status[RPO_RAW_LO_MSB:0]   = char_i.raw[RPO_RAW_LO_MSB:0];
            next_word.status[RPO_STAT_COMMA]     = char_i.comma;
        end else begin
            next_word.data   = char_i.decoded;
            next_word.status = char_i.code;
        end
    end

    // Load the register on each selected rising edge.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            word_o.data   <= RPO_DATA_RESET;
            word_o.status <= RPO_STAT_RESET;
        end else if (sel_rise) begin
            word_o <= next_word;
        end
    end

endmodule

/* File: rpo_top.sv */
`timescale 1ns/1ps
module rpo_top
    import rpo_pkg::*;
(
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    input  wire logic         training_clock_in_i,
    input  wire logic         output_clock_select_i,
    input  wire logic [1:0]   decoder_mode_select_i,
    input  wire logic         recovered_clock_ch_a_i,
    input  wire logic         recovered_clock_ch_b_i,
    input  wire logic         recovered_clock_ch_c_i,
    input  wire logic         recovered_clock_ch_d_i,
    input  wire rpo_char_type char_ch_a_i,
    input  wire rpo_char_type char_ch_b_i,
    input  wire rpo_char_type char_ch_c_i,
    input  wire rpo_char_type char_ch_d_i,
    output logic [7:0]        rx_char_bus_ch_a_o,
    output logic [7:0]        rx_char_bus_ch_b_o,
    output logic [7:0]        rx_char_bus_ch_c_o,
    output logic [7:0]        rx_char_bus_ch_d_o,
    output logic [2:0]        rx_status_bus_ch_a_o,
    output logic [2:0]        rx_status_bus_ch_b_o,
    output logic [2:0]        rx_status_bus_ch_c_o,
    output logic [2:0]        rx_status_bus_ch_d_o,
    output logic              recovered_clock_out_ch_a_o,
    output logic              recovered_clock_out_ch_b_o,
    output logic              recovered_clock_out_ch_c_o,
    output logic              recovered_clock_out_ch_d_o
);

    // ----------------------------------------------------------------
    // Shared pin synchronisers
    // ----------------------------------------------------------------
    logic       trg_meta;
    logic       trg_sync;
    logic       sel_meta;
    logic       sel_sync;
    logic [1:0] mode_meta;
    logic [1:0] mode_sync;

    // The training clock and the static mode pins pass two flip-flops.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            trg_meta  <= 1'b0;
            trg_sync  <= 1'b0;
            sel_meta  <= 1'b0;
            sel_sync  <= 1'b0;
            mode_meta <= RPO_MODE_LOW;
            mode_sync <= RPO_MODE_LOW;
        end else begin
            trg_meta  <= training_clock_in_i;
            trg_sync  <= trg_meta;
            sel_meta  <= output_clock_select_i;
            sel_sync  <= sel_meta;
            mode_meta <= decoder_mode_select_i;
            mode_sync <= mode_meta;
        end
    end

    // ----------------------------------------------------------------
    // Four independent channels sharing one mode
    // ----------------------------------------------------------------
    rpo_out_type word_a;
    rpo_out_type word_b;
    rpo_out_type word_c;
    rpo_out_type word_d;

    // Channel A output register.
    rpo_channel u_ch_a (
        .clock_i               (clock_i),
        .rst_i                 (rst_i),
        .recovered_clock_i     (recovered_clock_ch_a_i),
        .training_level_i      (trg_sync),
        .output_clock_select_i (sel_sync),
        .decoder_mode_i        (mode_sync),
        .char_i                (char_ch_a_i),
        .word_o                (word_a),
        .clock_out_o           (recovered_clock_out_ch_a_o)
    );

    // Channel B output register.
    rpo_channel u_ch_b (
        .clock_i               (clock_i),
        .rst_i                 (rst_i),
        .recovered_clock_i     (recovered_clock_ch_b_i),
        .training_level_i      (trg_sync),
        .output_clock_select_i (sel_sync),
        .decoder_mode_i        (mode_sync),
        .char_i                (char_ch_b_i),
        .word_o                (word_b),
        .clock_out_o           (recovered_clock_out_ch_b_o)
    );

    // Channel C output register.
    rpo_channel u_ch_c (
        .clock_i               (clock_i),
        .rst_i                 (rst_i),
        .recovered_clock_i     (recovered_clock_ch_c_i),
        .training_level_i      (trg_sync),
        .output_clock_select_i (sel_sync),
        .decoder_mode_i        (mode_sync),
        .char_i                (char_ch_c_i),
        .word_o                (word_c),
        .clock_out_o           (recovered_clock_out_ch_c_o)
    );

    // Channel D output register.
    rpo_channel u_ch_d (
        .clock_i               (clock_i),
        .rst_i                 (rst_i),
        .recovered_clock_i     (recovered_clock_ch_d_i),
        .training_level_i      (trg_sync),
        .output_clock_select_i (sel_sync),
        .decoder_mode_i        (mode_sync),
        .char_i                (char_ch_d_i),
        .word_o                (word_d),
        .clock_out_o           (recovered_clock_out_ch_d_o)
    );

    // ----------------------------------------------------------------
    // Bus outputs
    // ----------------------------------------------------------------
    // The channel words are flip-flops; these only split the struct.
    assign rx_char_bus_ch_a_o   = word_a.data;
    assign rx_char_bus_ch_b_o   = word_b.data;
    assign rx_char_bus_ch_c_o   = word_c.data;
    assign rx_char_bus_ch_d_o   = word_d.data;
    assign rx_status_bus_ch_a_o = word_a.status;
    assign rx_status_bus_ch_b_o = word_b.status;
    assign rx_status_bus_ch_c_o = word_c.status;
    assign rx_status_bus_ch_d_o = word_d.status;

endmodule

/* File: rpo_props.sv */
`timescale 1ns/1ps
module rpo_props
    import rpo_pkg::*;
(
    input wire logic         clock_i,
    input wire logic         rst_i,
    input wire logic [1:0]   decoder_mode_select_i,
    input wire rpo_char_type char_ch_a_i,
    input wire logic [7:0]   rx_char_bus_ch_a_o,
    input wire logic [2:0]   rx_status_bus_ch_a_o,
    input wire logic         recovered_clock_out_ch_a_o,
    input wire logic [7:0]   rx_char_bus_ch_b_o,
    input wire logic         recovered_clock_out_ch_b_o
);
    rpo_char_type cha_q;

    // Holds the character seen one cycle earlier, the one the design captures.
    always_ff @(posedge clock_i) begin
        cha_q <= char_ch_a_i;
    end

    // All checks share the system clock and its reset.
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    // An update of channel a with the mode pin settled, in bypass or decoded mode.
    sequence s_cap(bit byp);
        $rose(recovered_clock_out_ch_a_o) && decoder_mode_select_i == $past(decoder_mode_select_i, 4)
            && ((decoder_mode_select_i == 2'h0) == byp);
    endsequence

    a_bypass_data: assert property (s_cap(1) |-> rx_char_bus_ch_a_o == cha_q.raw[9:2])
        else $error("bypass data differs from raw high bits");
    a_bypass_low_bits: assert property (s_cap(1) |-> rx_status_bus_ch_a_o[1:0] == cha_q.raw[1:0])
        else $error("bypass status low bits differ from raw");
    a_bypass_comma: assert property (s_cap(1) |-> rx_status_bus_ch_a_o[2] == cha_q.comma)
        else $error("bypass comma flag wrong");
    a_decoded_data: assert property (s_cap(0) |-> rx_char_bus_ch_a_o == cha_q.decoded)
        else $error("decoded data wrong");
    a_decoded_status: assert property (s_cap(0) |-> rx_status_bus_ch_a_o == cha_q.code)
        else $error("decoded status wrong");
    a_hold_between: assert property (!$rose(recovered_clock_out_ch_a_o) |-> $stable({rx_char_bus_ch_a_o, rx_status_bus_ch_a_o}))
        else $error("channel a changed without a clock edge");
    a_channel_b_hold: assert property (!$rose(recovered_clock_out_ch_b_o) |-> $stable(rx_char_bus_ch_b_o))
        else $error("channel b changed without its own edge");

    c_bypass: cover property (s_cap(1));
    c_decoded: cover property (s_cap(0));
    c_channel_b: cover property ($rose(recovered_clock_out_ch_b_o) && !recovered_clock_out_ch_a_o);
endmodule

/* File: rpo_host_model.sv */
`timescale 1ns/1ps
module rpo_host_model (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        clk_out_i,
    input  wire logic [7:0]  data_i,
    input  wire logic [2:0]  status_i,
    output logic      [10:0] word_o
);
    logic prev;

    // Latches the presented word one cycle after the interface clock rises.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            prev <= 1'b0;
            word_o <= 11'h000;
        end else begin
            prev <= clk_out_i;
            if (clk_out_i && !prev) begin
                word_o <= {data_i, status_i};
            end
        end
    end
endmodule

/* File: tb_rpo_top.sv */
`timescale 1ns/1ps
module tb_rpo_top;
    import rpo_pkg::*;
    logic         clk = 1'b0;
    logic         rst_i = 1'b1;
    logic         trg = 1'b0;
    logic         sel = 1'b1;
    logic [1:0]   mode = 2'h2;
    logic [3:0]   rc = 4'h0;
    rpo_char_type ch [4];
    logic [7:0]   d [4];
    logic [2:0]   s [4];
    logic [3:0]   ck;
    logic [10:0]  host;
    int           num_errors = 0;
    int           num_checks = 0;
    int           cycles = 0;

    rpo_top u_dut (.clock_i(clk), .rst_i(rst_i), .training_clock_in_i(trg), .output_clock_select_i(sel),
        .decoder_mode_select_i(mode), .recovered_clock_ch_a_i(rc[0]), .recovered_clock_ch_b_i(rc[1]),
        .recovered_clock_ch_c_i(rc[2]), .recovered_clock_ch_d_i(rc[3]), .char_ch_a_i(ch[0]), .char_ch_b_i(ch[1]),
        .char_ch_c_i(ch[2]), .char_ch_d_i(ch[3]), .rx_char_bus_ch_a_o(d[0]), .rx_char_bus_ch_b_o(d[1]),
        .rx_char_bus_ch_c_o(d[2]), .rx_char_bus_ch_d_o(d[3]), .rx_status_bus_ch_a_o(s[0]),
        .rx_status_bus_ch_b_o(s[1]), .rx_status_bus_ch_c_o(s[2]), .rx_status_bus_ch_d_o(s[3]),
        .recovered_clock_out_ch_a_o(ck[0]), .recovered_clock_out_ch_b_o(ck[1]),
        .recovered_clock_out_ch_c_o(ck[2]), .recovered_clock_out_ch_d_o(ck[3]));
    rpo_host_model u_host (.clock_i(clk), .rst_i(rst_i), .clk_out_i(ck[0]), .data_i(d[0]), .status_i(s[0]),
        .word_o(host));

    // Free-running system clock and a hang limit.
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            end_of_test();
        end
    end

    function automatic rpo_char_type mk(input int n);
        return '{raw: 10'(n * 37 + 5), decoded: 8'(n * 53 + 3), code: 3'(n), comma: n[0]};
    endfunction

    // Expected word for the current mode: decoded byte and code, or raw bits and comma.
    function automatic logic [10:0] expw(input int n);
        rpo_char_type c;
        c = mk(n);
        return (mode == 2'h0) ? {c.raw[9:2], c.comma, c.raw[1:0]} : {c.decoded, c.code};
    endfunction

    task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Loads one character per channel and runs one 200 ns link clock period.
    task automatic pulse(input int base, input logic [3:0] m);
        foreach (ch[i]) ch[i] = mk(base + i);
        if (sel) rc = m;
        else trg = 1'b1;
        wait_cyc(4);
        chk("clock_out", {7'h00, (sel ? m : 4'hf)}, {7'h00, ck});
        rc = 4'h0;
        trg = 1'b0;
        wait_cyc(4);
        chk("clock_idle", 11'h000, {7'h00, ck});
    endtask

    task automatic chk_all(input int base);
        foreach (d[i]) chk($sformatf("ch%0d", i), expw(base + i), {d[i], s[i]});
    endtask

    task automatic t_modes;
        for (int md = 1; md < 4; md++) begin
            mode = 2'(md);
            wait_cyc(6);
            pulse(md * 8, 4'hf);
            chk_all(md * 8);
            chk("host", expw(md * 8), host);
        end
    endtask

    task automatic t_bypass;
        mode = 2'h0;
        wait_cyc(6);
        for (int k = 0; k < 4; k++) begin
            pulse(40 + k * 4, 4'hf);
            chk_all(40 + k * 4);
        end
        foreach (ch[i]) ch[i] = mk(90 + i);
        wait_cyc(9);
        chk_all(52);
        pulse(60, 4'h2);
        foreach (d[i]) chk("indep", expw(i == 1 ? 61 : 52 + i), {d[i], s[i]});
    endtask

    task automatic t_training;
        sel = 1'b0;
        wait_cyc(6);
        pulse(70, 4'h0);
        chk_all(70);
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Reset, then each scenario in turn.
    initial begin
        foreach (ch[i]) ch[i] = '0;
        wait_cyc(6);
        rst_i = 1'b0;
        foreach (d[i]) chk("reset", {RPO_DATA_RESET, RPO_STAT_RESET}, {d[i], s[i]});
        chk("reset_clock", 11'h000, {7'h00, ck});
        t_modes();
        t_bypass();
        t_training();
        end_of_test();
    end
endmodule

bind rpo_top rpo_props u_props (.clock_i(clock_i), .rst_i(rst_i), .decoder_mode_select_i(decoder_mode_select_i),
    .char_ch_a_i(char_ch_a_i), .rx_char_bus_ch_a_o(rx_char_bus_ch_a_o), .rx_status_bus_ch_a_o(rx_status_bus_ch_a_o),
    .recovered_clock_out_ch_a_o(recovered_clock_out_ch_a_o), .rx_char_bus_ch_b_o(rx_char_bus_ch_b_o),
    .recovered_clock_out_ch_b_o(recovered_clock_out_ch_b_o));
